//--- common/adcsq_pkg.sv
package adcsq_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] ADCSQ_OFF_CTRL = 5'h00;
  localparam logic [4:0] ADCSQ_OFF_STATUS = 5'h04;
  localparam logic [4:0] ADCSQ_OFF_RESULT = 5'h08;
  localparam logic [4:0] ADCSQ_OFF_INJECT = 5'h0c;
  localparam logic [4:0] ADCSQ_OFF_IRQ_ST = 5'h10;
  localparam logic [4:0] ADCSQ_OFF_IRQ_MASK = 5'h14;

  // Field positions of converter_control_reg
  localparam int ADCSQ_CTRL_MODE_LSB = 0;
  localparam int ADCSQ_CTRL_START = 2;
  localparam int ADCSQ_CTRL_WFR = 3;
  localparam int ADCSQ_CTRL_SUSP = 4;
  localparam int ADCSQ_CTRL_CTC_LSB = 6;
  localparam int ADCSQ_CTRL_STC_LSB = 8;
  localparam int ADCSQ_CTRL_CH_LSB = 12;
  localparam int ADCSQ_CTRL_INJCH_LSB = 16;
  localparam int ADCSQ_CTRL_INJREQ = 20;

  // Field positions inside result registers
  localparam int ADCSQ_RES_CH_LSB = 12;

  // Interrupt status / mask bit positions
  localparam int ADCSQ_IRQ_DONE = 0;
  localparam int ADCSQ_IRQ_OVR = 1;
  localparam int ADCSQ_IRQ_INJ = 2;

  // Conversion modes
  localparam logic [1:0] ADCSQ_MODE_SGL_ONCE = 2'h0;
  localparam logic [1:0] ADCSQ_MODE_SGL_CONT = 2'h1;
  localparam logic [1:0] ADCSQ_MODE_SCAN_ONCE = 2'h2;
  localparam logic [1:0] ADCSQ_MODE_SCAN_CONT = 2'h3;

  // Timing in base clock phases; one system clock holds two phases
  localparam int ADCSQ_PHASE_PER_CLK = 2;
  localparam int ADCSQ_TCC_PHASE_00 = 24;
  localparam int ADCSQ_TCC_PHASE_10 = 96;
  localparam int ADCSQ_TCC_PHASE_11 = 48;
  localparam int ADCSQ_CONV_TCC = 14;
  localparam int ADCSQ_SAMPLE_TSC = 2;
  localparam int ADCSQ_XFER_PHASE = 4;
  localparam int ADCSQ_CAL_TCC = 4;
  localparam logic [15:0] ADCSQ_XFER_CLKS = 16'(ADCSQ_XFER_PHASE / ADCSQ_PHASE_PER_CLK);

  // Reset calibration length, rounded up to whole clocks
  localparam real ADCSQ_CLK_MHZ = 40.0;
  localparam real ADCSQ_RESET_CAL_MS = 1.25;
  localparam int ADCSQ_RESET_CAL_CYCLES = int'($ceil(ADCSQ_RESET_CAL_MS * 1000.0 * ADCSQ_CLK_MHZ));

  // Reset values
  localparam logic [31:0] ADCSQ_RST_WORD = 32'h0000_0000;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ADCSQ_IDLE = 6'h01,
    ADCSQ_SAMPLE = 6'h02,
    ADCSQ_CONVERT = 6'h04,
    ADCSQ_XFER = 6'h08,
    ADCSQ_HOLD = 6'h10,
    ADCSQ_CAL = 6'h20
  } adcsq_state_e;

endpackage

//--- rtl/adcsq_top.sv
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int RESET_CAL_CYCLES = ADCSQ_RESET_CAL_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Analog core
  input wire logic [9:0] ana_result_in,
  output logic [3:0] ana_channel_out,
  output logic ana_sample_out,
  output logic ana_convert_out,
  output logic ana_cal_out,
  // Status and events
  output logic converter_busy_flag_out,
  output logic conv_request_out,
  output logic irq_out
);

  // Whole module state
  typedef struct packed {
    adcsq_state_e fsm;        // Sequencer state
    logic [1:0] mode;         // Conversion mode
    logic wait_for_read_bit;  // Hold results until read in continuous modes
    logic ovr_suspend;        // Overrun handling: 1 suspends, 0 interrupts
    // Clock selects are read at every phase load, so a change
    // made mid-conversion only affects the phases that follow
    logic [1:0] conv_clock_select;
    logic [1:0] sample_clock_select;
    logic [3:0] sel_ch;       // Selected / scan top channel
    logic [3:0] inj_ch;       // Channel for injection
    logic inj_req;            // Injection pending
    logic running;            // Sequence active
    logic [3:0] cur_ch;       // Next channel of the sequence
    logic [3:0] conv_ch;      // Channel under conversion
    logic cur_inj;            // Current conversion is injected
    // Sixteen bits cover the longest phase and the reset calibration
    // at its default length
    logic [15:0] phase_cnt;   // Clocks left in this phase
    logic [15:0] cal_cnt;     // Reset calibration clocks left
    // Result registers, each with the channel it came from
    logic [9:0] result;       // conv_result_reg value field
    logic [3:0] result_ch;
    logic unread;             // Result not yet read
    logic [9:0] temp_buf;     // Waiting result
    logic [3:0] temp_ch;
    logic [9:0] inj_result;   // inject_result_reg value field
    logic [3:0] inj_result_ch;
    logic [2:0] irq_st;       // Sticky events
    logic [2:0] irq_mask;
    // Bus slave answer registers
    logic waitreq;
    logic [31:0] readdata;
    logic [9:0] sync1;        // First synchroniser stage
    logic [9:0] sync2;        // Second synchroniser stage
    // Registered outputs
    logic done_pulse;
    logic irq;
    logic busy;
    logic cal_out;
  } adcsq_state_s;

  adcsq_state_s st;
  adcsq_state_s next_st;

  // Conversion clock period in system clocks; reserved code acts as 00
  // Periods are whole system clocks: two base phases per clock
  function automatic logic [15:0] tcc_clks(input logic [1:0] code);
    case (code)
      2'b10: tcc_clks = 16'(ADCSQ_TCC_PHASE_10 / ADCSQ_PHASE_PER_CLK);
      2'b11: tcc_clks = 16'(ADCSQ_TCC_PHASE_11 / ADCSQ_PHASE_PER_CLK);
      default: tcc_clks = 16'(ADCSQ_TCC_PHASE_00 / ADCSQ_PHASE_PER_CLK);
    endcase
  endfunction

  // Sample phase length: two sample periods of tcc shifted by code
  function automatic logic [15:0] sample_clks(input logic [1:0] ctc, input logic [1:0] stc);
    sample_clks = 16'(tcc_clks(ctc) * ADCSQ_SAMPLE_TSC) << stc;
  endfunction

  // Byte-lane merge for register writes
  // Lanes not enabled keep their old value
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (wd & m);
  endfunction

  // Scans run from the channel field down to channel 0
  // Sequence advance after a stored result: {running, next channel}
  function automatic logic [4:0] advance(input logic [1:0] mode, input logic [3:0] cur,
                                         input logic [3:0] sel);
    case (mode)
      ADCSQ_MODE_SGL_ONCE: advance = {1'b0, cur};
      ADCSQ_MODE_SGL_CONT: advance = {1'b1, cur};
      ADCSQ_MODE_SCAN_ONCE: advance = (cur == 4'h0) ? {1'b0, sel}
                                                    : {1'b1, cur - 4'h1};
      default: advance = (cur == 4'h0) ? {1'b1, sel} : {1'b1, cur - 4'h1};
    endcase
  endfunction

  // Next-state logic for bus, sequencer and interrupts
  always_comb begin
    logic [31:0] ctrl_word;
    logic [31:0] wr_word;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic rd_result;
    logic [4:0] adv;
    // Defaults keep the process free of latches
    ctrl_word = ADCSQ_RST_WORD;
    wr_word = ADCSQ_RST_WORD;
    irq_set = 3'h0;
    irq_clr = 3'h0;
    rd_result = 1'b0;
    adv = 5'h00;
    // Every field but done_pulse and the synchroniser holds unless a branch below changes it
    next_st = st;
    next_st.done_pulse = 1'b0;
    // Synchroniser for the comparator result coming from the analog side
    next_st.sync1 = ana_result_in;
    next_st.sync2 = st.sync1;

    // Control word image for reads and byte-lane writes
    ctrl_word[ADCSQ_CTRL_MODE_LSB +: 2] = st.mode;
    ctrl_word[ADCSQ_CTRL_START] = st.running;
    ctrl_word[ADCSQ_CTRL_WFR] = st.wait_for_read_bit;
    ctrl_word[ADCSQ_CTRL_SUSP] = st.ovr_suspend;
    ctrl_word[ADCSQ_CTRL_CTC_LSB +: 2] = st.conv_clock_select;
    ctrl_word[ADCSQ_CTRL_STC_LSB +: 2] = st.sample_clock_select;
    ctrl_word[ADCSQ_CTRL_CH_LSB +: 4] = st.sel_ch;
    ctrl_word[ADCSQ_CTRL_INJCH_LSB +: 4] = st.inj_ch;
    ctrl_word[ADCSQ_CTRL_INJREQ] = st.inj_req;

    // Bus slave: one wait cycle, then answer for exactly one cycle
    if (st.waitreq) begin
      if (avs_read_in || avs_write_in) begin
        next_st.waitreq = 1'b0;
        case (avs_address_in)
          ADCSQ_OFF_CTRL: next_st.readdata = ctrl_word;
          // Status: next channel, hold, unread, reset calibration, busy
          ADCSQ_OFF_STATUS: next_st.readdata = {24'h000000, st.cur_ch, st.fsm == ADCSQ_HOLD,
                                                st.unread, st.cal_cnt != 16'h0000, st.busy};
          ADCSQ_OFF_RESULT: next_st.readdata = {16'h0000, st.result_ch, 2'h0, st.result};
          ADCSQ_OFF_INJECT: next_st.readdata = {16'h0000, st.inj_result_ch, 2'h0,
                                                st.inj_result};
          ADCSQ_OFF_IRQ_ST: next_st.readdata = {29'h00000000, st.irq_st};
          ADCSQ_OFF_IRQ_MASK: next_st.readdata = {29'h00000000, st.irq_mask};
          default: next_st.readdata = ADCSQ_RST_WORD; // Unmapped reads zero
        endcase
      end
    end else begin
      // The master samples waitrequest low at this edge: commit the access
      next_st.waitreq = 1'b1;
      if (avs_write_in) begin
        case (avs_address_in)
          ADCSQ_OFF_CTRL: begin
            wr_word = be_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
            next_st.mode = wr_word[ADCSQ_CTRL_MODE_LSB +: 2];
            next_st.wait_for_read_bit = wr_word[ADCSQ_CTRL_WFR];
            next_st.ovr_suspend = wr_word[ADCSQ_CTRL_SUSP];
            next_st.conv_clock_select = wr_word[ADCSQ_CTRL_CTC_LSB +: 2];
            next_st.sample_clock_select = wr_word[ADCSQ_CTRL_STC_LSB +: 2];
            next_st.sel_ch = wr_word[ADCSQ_CTRL_CH_LSB +: 4];
            next_st.inj_ch = wr_word[ADCSQ_CTRL_INJCH_LSB +: 4];
            // Injection is only meaningful while a continuous mode runs
            if (wr_word[ADCSQ_CTRL_INJREQ]) begin
              next_st.inj_req = 1'b1;
            end
            // Start while idle loads the first channel of the sequence
            if (avs_byteenable_in[0] && avs_writedata_in[ADCSQ_CTRL_START] && !st.running) begin
              next_st.running = 1'b1;
              next_st.cur_ch = wr_word[ADCSQ_CTRL_CH_LSB +: 4];
            end
          end
          ADCSQ_OFF_IRQ_ST: begin
            irq_clr = avs_writedata_in[2:0] & {3{avs_byteenable_in[0]}};
          end
          ADCSQ_OFF_IRQ_MASK: begin
            wr_word = be_merge({29'h00000000, st.irq_mask}, avs_writedata_in, avs_byteenable_in);
            next_st.irq_mask = wr_word[2:0];
          end
          default: begin
            // Writes to read-only or unmapped offsets are dropped
          end
        endcase
      end
      // Reading the result is what frees an unread or parked value
      if (avs_read_in && avs_address_in == ADCSQ_OFF_RESULT) begin
        rd_result = 1'b1;
        next_st.unread = 1'b0;
      end
    end

    // Conversion sequencer
    case (st.fsm)
      // Idle: pick the injected or the next sequence channel
      ADCSQ_IDLE: begin
        // Reset calibration only advances while the converter is free,
        // so conversions in between stretch it out
        if (st.cal_cnt != 16'h0000) begin
          next_st.cal_cnt = st.cal_cnt - 16'h0001;
        end
        if (st.running) begin
          // Injection wins over the sequence, in continuous modes only
          if (st.inj_req && st.mode[0]) begin
            next_st.conv_ch = st.inj_ch;
            next_st.cur_inj = 1'b1;
            next_st.inj_req = 1'b0;
          end else begin
            next_st.conv_ch = st.cur_ch;
            next_st.cur_inj = 1'b0;
          end
          next_st.fsm = ADCSQ_SAMPLE;
          next_st.phase_cnt = sample_clks(st.conv_clock_select, st.sample_clock_select)
                              - 16'h0001;
        end
      end
      // Sample phase: two sample periods with the mux held
      ADCSQ_SAMPLE: begin
        if (st.phase_cnt == 16'h0000) begin
          next_st.fsm = ADCSQ_CONVERT;
          next_st.phase_cnt = 16'(tcc_clks(st.conv_clock_select) * ADCSQ_CONV_TCC)
                              - 16'h0001;
        end else begin
          next_st.phase_cnt = st.phase_cnt - 16'h0001;
        end
      end
      // Conversion phase: fourteen conversion periods
      ADCSQ_CONVERT: begin
        if (st.phase_cnt == 16'h0000) begin
          next_st.fsm = ADCSQ_XFER;
          next_st.phase_cnt = ADCSQ_XFER_CLKS - 16'h0001;
        end else begin
          next_st.phase_cnt = st.phase_cnt - 16'h0001;
        end
      end
      // Transfer phase: the result is taken from the second
      // synchroniser stage on its last clock
      ADCSQ_XFER: begin
        if (st.phase_cnt != 16'h0000) begin
          next_st.phase_cnt = st.phase_cnt - 16'h0001;
        end else begin
          next_st.fsm = ADCSQ_CAL;
          next_st.phase_cnt = 16'(tcc_clks(st.conv_clock_select) * ADCSQ_CAL_TCC) - 16'h0001;
          if (st.cur_inj) begin
            // Injected result bypasses the main result and its overrun check
            next_st.inj_result = st.sync2;
            next_st.inj_result_ch = st.conv_ch;
            irq_set[ADCSQ_IRQ_INJ] = 1'b1;
          end else if (st.unread && !rd_result
                       && (st.ovr_suspend || (st.wait_for_read_bit && st.mode[0]))) begin
            // Park the new result; the converter stays on hold
            next_st.temp_buf = st.sync2;
            next_st.temp_ch = st.conv_ch;
            next_st.fsm = ADCSQ_HOLD;
          end else begin
            if (st.unread && !rd_result) begin
              irq_set[ADCSQ_IRQ_OVR] = 1'b1;
            end
            next_st.result = st.sync2;
            next_st.result_ch = st.conv_ch;
            next_st.unread = 1'b1;
            next_st.done_pulse = 1'b1;
            irq_set[ADCSQ_IRQ_DONE] = 1'b1;
            adv = advance(st.mode, st.cur_ch, st.sel_ch);
            next_st.running = adv[4];
            next_st.cur_ch = adv[3:0];
          end
        end
      end
      ADCSQ_HOLD: begin
        // The read that frees the old result releases the parked one
        // Without a read the converter stays parked here
        if (rd_result) begin
          next_st.result = st.temp_buf;
          next_st.result_ch = st.temp_ch;
          next_st.unread = 1'b1;
          next_st.done_pulse = 1'b1;
          irq_set[ADCSQ_IRQ_DONE] = 1'b1;
          adv = advance(st.mode, st.cur_ch, st.sel_ch);
          next_st.running = adv[4];
          next_st.cur_ch = adv[3:0];
          next_st.fsm = ADCSQ_CAL;
          next_st.phase_cnt = 16'(tcc_clks(st.conv_clock_select) * ADCSQ_CAL_TCC) - 16'h0001;
        end
      end
      ADCSQ_CAL: begin
        // Per-conversion calibration before the converter is free again
        // Busy stays high through the whole count
        if (st.phase_cnt == 16'h0000) begin
          next_st.fsm = ADCSQ_IDLE;
        end else begin
          next_st.phase_cnt = st.phase_cnt - 16'h0001;
        end
      end
      // Illegal state codes fall back to idle
      default: begin
        next_st.fsm = ADCSQ_IDLE;
      end
    endcase

    // Sticky events: a new event wins over a clear in the same cycle
    next_st.irq_st = (st.irq_st & ~irq_clr) | irq_set;
    // Level interrupt from the next status and mask
    next_st.irq = |(next_st.irq_st & next_st.irq_mask);
    // Busy covers calibration, any phase and a pending sequence
    next_st.busy = (next_st.cal_cnt != 16'h0000) || (next_st.fsm != ADCSQ_IDLE)
                   || next_st.running;
    // Calibration output covers both kinds of calibration
    next_st.cal_out = (next_st.fsm == ADCSQ_CAL)
                      || (next_st.fsm == ADCSQ_IDLE && next_st.cal_cnt != 16'h0000);
  end

  // State register; the enable freezes everything
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Clear everything, then give the non-zero reset values
      st <= '0;
      st.fsm <= ADCSQ_IDLE;
      st.waitreq <= 1'b1;
      st.cal_cnt <= 16'(RESET_CAL_CYCLES);
      st.busy <= 1'b1;
      st.cal_out <= 1'b1;
    end else if (clk_en_in) begin
      // A low enable holds every field, the bus answer included
      st <= next_st;
    end
  end

  // Outputs straight from state bits
  // Read data stands until the next answer
  assign avs_readdata_out = st.readdata;
  assign avs_waitrequest_out = st.waitreq;
  assign ana_channel_out = st.conv_ch;
  // Sample and convert outputs are bits of the one-hot state code; the calibration output is registered
  assign ana_sample_out = st.fsm[1];
  assign ana_convert_out = st.fsm[2];
  assign ana_cal_out = st.cal_out;
  assign converter_busy_flag_out = st.busy;
  // One-cycle request for software or a transfer unit
  assign conv_request_out = st.done_pulse;
  assign irq_out = st.irq;

endmodule

//--- sim/adcsq_sva.sv
`timescale 1ns/1ps
// Port-level checker for the converter sequencer
module adcsq_sva (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Bus handshake
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Converter side
  input wire logic [3:0] ana_channel_out,
  input wire logic ana_sample_out,
  input wire logic ana_convert_out,
  input wire logic ana_cal_out,
  input wire logic converter_busy_flag_out,
  input wire logic conv_request_out
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  chk_bus_answer: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out && clk_en_in |=> !avs_waitrequest_out)
    else $error("bus request not answered after one wait cycle");
  chk_wait_single: assert property (
    !avs_waitrequest_out && clk_en_in |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  chk_req_pulse: assert property (
    conv_request_out && clk_en_in |=> !conv_request_out)
    else $error("transfer request longer than one cycle");
  chk_busy_active: assert property (
    ana_sample_out || ana_convert_out || conv_request_out |-> converter_busy_flag_out)
    else $error("busy low while converting");
  chk_sample_min: assert property (
    $rose(ana_sample_out) |-> ana_sample_out [*8])
    else $error("sample phase too short");
  chk_sample_conv: assert property (
    $fell(ana_sample_out) |-> ana_convert_out && !ana_sample_out)
    else $error("convert phase does not follow sampling");
  chk_conv_chan: assert property (
    ana_convert_out && $past(ana_convert_out) |-> $stable(ana_channel_out))
    else $error("channel moved during conversion");
  chk_cal_follow: assert property (
    conv_request_out |-> ##[0:3] ana_cal_out)
    else $error("no calibration cycle after a conversion");
  chk_reset_cal: assert property (
    $past(rst_in) |-> converter_busy_flag_out && ana_cal_out)
    else $error("reset calibration not running after reset");
endmodule

// Attach to every instance of the sequencer
bind adcsq_top adcsq_sva adcsq_sva_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .clk_en_in(clk_en_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .ana_channel_out(ana_channel_out),
  .ana_sample_out(ana_sample_out), .ana_convert_out(ana_convert_out),
  .ana_cal_out(ana_cal_out), .converter_busy_flag_out(converter_busy_flag_out),
  .conv_request_out(conv_request_out));

//--- sim/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench: drives the bus and the analog core pins directly
module tb_top import adcsq_pkg::*; ;
  // Design pins
  logic sys_clk_in, rst_in, clk_en_in, avs_read_in, avs_write_in;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [3:0] avs_byteenable_in, ana_channel_out;
  logic [9:0] ana_result_in;
  logic avs_waitrequest_out, ana_sample_out, ana_convert_out, ana_cal_out;
  logic converter_busy_flag_out, conv_request_out, irq_out;
  // Counters, per-channel analog levels, expectation queues
  int n_errors, n_compared, seed, npulse, ns, nc, ncal, p, t;
  int mq[$];
  int eq[$];
  logic [9:0] tab[16];

  // Short reset calibration keeps the run brief
  adcsq_top #(.RESET_CAL_CYCLES(20)) adcsq_top_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .clk_en_in(clk_en_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .ana_result_in(ana_result_in),
    .ana_channel_out(ana_channel_out), .ana_sample_out(ana_sample_out),
    .ana_convert_out(ana_convert_out), .ana_cal_out(ana_cal_out),
    .converter_busy_flag_out(converter_busy_flag_out), .conv_request_out(conv_request_out),
    .irq_out(irq_out));

  // 40 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // Each channel shows its own level, so a wrong mux select shows in the data
  always @(posedge sys_clk_in) ana_result_in <= tab[ana_channel_out];

  // Phase lengths of each conversion, logged when its request pulses
  always @(posedge sys_clk_in) begin
    ns += int'(ana_sample_out && clk_en_in);
    nc += int'(ana_convert_out && clk_en_in);
    if (conv_request_out === 1'b1 && clk_en_in) begin
      mq.push_back(ns + nc);
      ns = 0;
      nc = 0;
      ncal = 0;
      npulse++;
    end
    // Calibration starts with the request cycle, so count it after the clear
    ncal += int'(ana_cal_out && clk_en_in);
  end

  // Conversion clock in system clocks; the reserved code runs as code 00
  function automatic int tcc(input int c);
    case (c)
      2: return ADCSQ_TCC_PHASE_10 / ADCSQ_PHASE_PER_CLK;
      3: return ADCSQ_TCC_PHASE_11 / ADCSQ_PHASE_PER_CLK;
      default: return ADCSQ_TCC_PHASE_00 / ADCSQ_PHASE_PER_CLK;
    endcase
  endfunction
  // Control word with the start bit set
  function automatic logic [31:0] cw(input int m, ctc, stc, ch, hold, inj);
    return 32'(m + 4 + (hold << 3) + (ctc << 6) + (stc << 8) + (ch << 12) + (inj << 16));
  endfunction
  // Result word: level in the low bits, channel above
  function automatic logic [31:0] res(input int ch);
    return 32'((ch << 12) + int'(tab[ch]));
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge sys_clk_in);
    chk(32'(k < 50), 32'h1);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Wait for the next transfer request, bounded
  task automatic wait_pulse();
    int k;
    k = 0;
    p = npulse;
    while (npulse == p && k < 5000) begin
      @(posedge sys_clk_in);
      k++;
    end
    chk(32'(k < 5000), 32'h1);
  endtask
  // Wait for busy to drop; reading the result releases any held conversion
  task automatic wait_idle();
    int k;
    k = 0;
    while (converter_busy_flag_out !== 1'b0 && k < 300) begin
      bus(1'b0, ADCSQ_OFF_RESULT, 32'h0);
      repeat (20) @(posedge sys_clk_in);
      k++;
    end
    chk(32'(k < 300), 32'h1);
  endtask
  // Compare each result with the model: phase lengths, channel order, level
  task automatic conv(input int ctc, input int stc, input int n);
    repeat (n) begin
      wait_pulse();
      chk(32'(mq.pop_front()), 32'(2 * (tcc(ctc) << stc) + 14 * tcc(ctc)));
      rdc(ADCSQ_OFF_RESULT, res(eq.pop_front()));
    end
  endtask
  task automatic stop_run();
    wr(ADCSQ_OFF_CTRL, 32'h0);
    wait_idle();
    wr(ADCSQ_OFF_IRQ_ST, 32'h7);
    mq.delete();
    eq.delete();
  endtask
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard: the sequence needs about 20000 clocks
  initial begin
    #2000000;
    n_errors++;
    finish_test();
  end

  initial begin
    seed = 50;
    rst_in = 1'b1;
    clk_en_in = 1'b1;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hf;
    ana_result_in = 10'h000;
    foreach (tab[i]) tab[i] = 10'($random(seed));
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    // Reset values, calibration running, unmapped place
    rdc(ADCSQ_OFF_STATUS, 32'h3);
    rdc(ADCSQ_OFF_CTRL, 32'h0);
    rdc(ADCSQ_OFF_IRQ_MASK, 32'h0);
    rdc(5'h18, 32'h0);
    wait_idle();
    wr(ADCSQ_OFF_IRQ_MASK, 32'h7);
    // Every clock code pair, single once on a random channel
    for (int i = 0; i < 16; i++) begin
      eq.push_back($random(seed) & 15);
      wr(ADCSQ_OFF_CTRL, cw(0, i / 4, i % 4, eq[0], 0, 0));
      conv(i / 4, i % 4, 1);
      wait_idle();
      chk(32'(ncal), 32'(4 * tcc(i / 4)));
      chk(32'(irq_out), 32'h1);
      wr(ADCSQ_OFF_IRQ_ST, 32'h7);
    end
    // Scan once downwards, continuous scan with reload, continuous single
    eq = '{3, 2, 1, 0};
    wr(ADCSQ_OFF_CTRL, cw(2, 0, 0, 3, 0, 0));
    conv(0, 0, 4);
    wait_idle();
    eq = '{1, 0, 1, 0, 1};
    wr(ADCSQ_OFF_CTRL, cw(3, 3, 1, 1, 0, 0));
    conv(3, 1, 5);
    stop_run();
    eq = '{6, 6, 6};
    wr(ADCSQ_OFF_CTRL, cw(1, 0, 2, 6, 0, 0));
    conv(0, 2, 3);
    stop_run();
    // Unread result raises overrun; overrun then masked and done cleared
    wr(ADCSQ_OFF_CTRL, cw(1, 0, 0, 7, 0, 0));
    wait_pulse();
    wait_pulse();
    repeat (2) @(posedge sys_clk_in);
    chk(32'(irq_out), 32'h1);
    rdc(ADCSQ_OFF_IRQ_ST, 32'h3);
    wr(ADCSQ_OFF_IRQ_MASK, 32'h5);
    wr(ADCSQ_OFF_IRQ_ST, 32'h1);
    @(posedge sys_clk_in);
    chk(32'(irq_out), 32'h0);
    rdc(ADCSQ_OFF_RESULT, res(7));
    stop_run();
    wr(ADCSQ_OFF_IRQ_MASK, 32'h7);
    // Wait-for-read, then suspend: no new result until a read
    for (int h = 1; h < 3; h++) begin
      wr(ADCSQ_OFF_CTRL, cw(1, 0, 0, 9, h, 0));
      wait_pulse();
      t = npulse;
      repeat (600) @(posedge sys_clk_in);
      chk(32'(npulse), 32'(t));
      bus(1'b0, ADCSQ_OFF_STATUS, 32'h0);
      chk(rd & 32'h8, 32'h8);
      t = npulse;
      rdc(ADCSQ_OFF_RESULT, res(9));
      repeat (2) @(posedge sys_clk_in);
      chk(32'(npulse), 32'(t + 1));
      stop_run();
    end
    // Injected channel during a continuous scan, scan carries on
    wr(ADCSQ_OFF_CTRL, cw(3, 0, 0, 2, 0, 0));
    wr(ADCSQ_OFF_CTRL, cw(3, 0, 0, 2, 0, 27));
    t = 0;
    do begin
      bus(1'b0, ADCSQ_OFF_IRQ_ST, 32'h0);
      t++;
    end while (rd[2] !== 1'b1 && t < 400);
    chk(32'(t < 400), 32'h1);
    rdc(ADCSQ_OFF_INJECT, res(11));
    bus(1'b0, ADCSQ_OFF_RESULT, 32'h0);
    wait_pulse();
    bus(1'b0, ADCSQ_OFF_RESULT, 32'h0);
    chk(rd, res(1));
    chk(32'(converter_busy_flag_out), 32'h1);
    stop_run();
    // Reset in mid-conversion, then convert inside the reset calibration
    wr(ADCSQ_OFF_CTRL, cw(0, 0, 0, 4, 0, 0));
    repeat (50) @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    ns = 0;
    nc = 0;
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    eq.push_back(4);
    wr(ADCSQ_OFF_CTRL, cw(0, 0, 0, 4, 0, 0));
    // Enable low mid-conversion must leave the phase lengths unchanged
    repeat (30) @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    repeat (25) @(posedge sys_clk_in);
    clk_en_in <= 1'b1;
    conv(0, 0, 1);
    bus(1'b0, ADCSQ_OFF_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    wait_idle();
    finish_test();
  end
endmodule
